//--- tb/adr_host_model.sv
/* Host side of the register port.
   Assumes the bank answers a read one cycle after it is taken. */
`timescale 1ns/100ps
`default_nettype none
module adr_host_model
    import adr_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Register port.
    output var adr_req_t req,
    input wire logic [7:0] rdata_q,
    input wire logic rvalid_q
);
    initial req = '0;
    // One strobe per call; the answer is due within one cycle, so no longer wait is needed.
    task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
        output logic [7:0] data, output logic ok);
        @(negedge clock);
        req = '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(negedge clock);
        req = '0;
        ok = !rd || rvalid_q;
        data = rdata_q;
    endtask
endmodule
`default_nettype wire

//--- tb/adr_regs_properties.sv
/* Port checker for the register bank.
   Assumes it is bound to adr_regs and sees its clock and reset. */
`timescale 1ns/100ps
`default_nettype none
module adr_regs_props
    import adr_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a,
    parameter int FILL_W = 7
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports.
    input wire adr_req_t req,
    input wire logic [7:0] rdata_q,
    input wire logic fifo_pop_q,
    input wire logic overrun_event,
    input wire logic [FILL_W-1:0] fifo_fill_count,
    input wire logic [7:0] fifo_read_data,
    input wire adr_scale_t scale_q,
    input wire logic suspend_q
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Every read answer is tied to the address taken one edge before.
    id_read_a:
        assert property (req.rd && req.addr == ADR_OFS_CHIP_IDENTITY |=> rdata_q == IDENTITY_VALUE)
        else $error("identity byte wrong");
    nibble_zero_a:
        assert property (req.rd && req.addr inside {8'h02, 8'h04, 8'h06} |=> rdata_q[3:0] == 4'h0)
        else $error("low result byte has reserved bits set");
    fill_count_a:
        assert property (req.rd && req.addr == ADR_OFS_FIFO_STATUS
            |=> rdata_q[FILL_W-1:0] == $past(fifo_fill_count, 2)) else $error("fill count wrong");
    overrun_seen_a:
        assert property (overrun_event ##1 (req.rd && req.addr == ADR_OFS_FIFO_STATUS) |=> rdata_q[7])
        else $error("overrun flag not set");
    pop_read_a:
        assert property (req.rd && req.addr == ADR_OFS_FIFO_READ_PORT
            |=> fifo_pop_q && rdata_q == $past(fifo_read_data)) else $error("FIFO port read wrong");
    pop_only_a:
        assert property (!(req.rd && req.addr == ADR_OFS_FIFO_READ_PORT) |=> !fifo_pop_q)
        else $error("spurious FIFO pop");
    suspend_write_a:
        assert property (req.wr && req.addr == ADR_OFS_POWER_MODE |=> suspend_q == $past(req.wdata[7]))
        else $error("suspend bit not taken");
    scale_four_a:
        assert property (req.wr && req.addr == ADR_OFS_RANGE_SELECT && req.wdata[3:0] == ADR_RANGE_4G
            |=> ##1 scale_q == ADR_SCALE_4G) else $error("range code not decoded");
    cover property (req.rd && req.addr == ADR_OFS_FIFO_READ_PORT);
    cover property (overrun_event ##1 req.rd);
    cover property (req.wr && req.addr == ADR_OFS_POWER_MODE && req.wdata[7]);
endmodule
`default_nettype wire

//--- tb/test_accel_data_status_regs.sv
/* Self-checking bench for the register bank.
   Assumes the host model and the port checker beside it. */
`timescale 1ns/100ps
`default_nettype none
module test_accel_data_status_regs;
    import adr_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, overrun_event = 1'b0;
    logic [11:0] x_accel_result = 12'habc, y_accel_result = 12'h123, z_accel_result = 12'h7f5;
    logic fifo_watermark_flag = 1'b0;
    logic [6:0] fifo_fill_count = 7'h15;
    logic [7:0] fifo_read_data = 8'h9c;
    logic rvalid_q, fifo_pop_q, suspend_q;
    logic [7:0] rdata_q;
    adr_req_t req;
    adr_scale_t scale_q;
    int failures = 0, total_checks = 0;
    // Address and expected byte; origin z and x, polarity y.
    logic [15:0] rows [14] = '{16'h005a, 16'h0100, 16'h02c0, 16'h03ab, 16'h0430, 16'h0512,
        16'h0650, 16'h077f, 16'h0800, 16'h0905, 16'h0aa0, 16'h0b25, 16'h0c15, 16'h0f03};
    // Range code and decoded scale; code zero is left undefined.
    logic [5:0] codes [4] = '{6'h0c, 6'h15, 6'h22, 6'h03};
    always #2 clock = ~clock;
    adr_host_model host (.clock, .req, .rdata_q, .rvalid_q);
    adr_regs uut (.clock, .rst_n, .req, .rdata_q, .rvalid_q, .fifo_pop_q, .sample_valid,
        .x_accel_result, .y_accel_result, .z_accel_result, .significant_motion_flag(1'b1),
        .slope_motion_flag(1'b1), .slope_report('{origin: 3'b101, polarity: 3'b010}),
        .fifo_full_flag(1'b1), .fifo_watermark_flag, .new_sample_flag(1'b1),
        .overrun_event, .fifo_fill_count, .fifo_read_data, .scale_q, .suspend_q);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.access(1'b1, addr, 8'h00, d, ok);
        check("read valid", 8'h01, {7'h00, ok});
        check($sformatf("register %h", addr), exp, d);
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        logic ok;
        host.access(1'b0, addr, data, d, ok);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock) s = 1'b1;
        @(negedge clock) s = 1'b0;
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // A hang is cut short and counted as a mismatch.
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
    // Main sequence: table reads first, then the awkward cases.
    initial
    begin
        repeat (4) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        pulse(sample_valid);
        for (int i = 0; i < 14; i++)
            rd_chk(rows[i][15:8], rows[i][7:0]);
        $display("table done");
        pulse(overrun_event);
        rd_chk(ADR_OFS_FIFO_STATUS, 8'h95);
        rd_chk(ADR_OFS_FIFO_READ_PORT, 8'h9c);
        rd_chk(ADR_OFS_FIFO_STATUS, 8'h15);
        // Moved levels must reach the status bytes and the data port.
        @(negedge clock);
        fifo_watermark_flag = 1'b1;
        fifo_fill_count = 7'h2a;
        fifo_read_data = 8'h63;
        rd_chk(ADR_OFS_DATA_FIFO_STATUS, 8'he0);
        rd_chk(ADR_OFS_FIFO_STATUS, 8'h2a);
        rd_chk(ADR_OFS_FIFO_READ_PORT, 8'h63);
        $display("overrun done");
        // Suspend first so the range change never disturbs a conversion.
        wr(ADR_OFS_POWER_MODE, 8'h80);
        rd_chk(ADR_OFS_POWER_MODE, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADR_OFS_RANGE_SELECT, {4'hf, codes[i][5:2]});
            rd_chk(ADR_OFS_RANGE_SELECT, {4'h0, codes[i][5:2]});
            check("scale", {6'h00, codes[i][1:0]}, {6'h00, scale_q});
        end
        x_accel_result = 12'h000;
        pulse(sample_valid);
        rd_chk(ADR_OFS_X_HIGH, 8'hab);
        wr(ADR_OFS_POWER_MODE, 8'h00);
        check("suspend", 8'h00, {7'h00, suspend_q});
        wr(ADR_OFS_X_LOW, 8'hff);
        rd_chk(ADR_OFS_X_LOW, 8'hc0);
        $display("range and suspend done");
        @(negedge clock) rst_n = 1'b0;
        repeat (4) @(negedge clock);
        check("reset scale", 8'h00, {6'h00, scale_q});
        rst_n = 1'b1;
        rd_chk(ADR_OFS_RANGE_SELECT, 8'h03);
        rd_chk(ADR_OFS_X_HIGH, 8'h00);
        $display("reset done");
        finish_test();
    end
endmodule
bind adr_regs adr_regs_props #(.IDENTITY_VALUE(IDENTITY_VALUE), .FILL_W(FILL_W)) props (.clock,
    .rst_n, .req, .rdata_q, .fifo_pop_q, .overrun_event, .fifo_fill_count, .fifo_read_data,
    .scale_q, .suspend_q);
`default_nettype wire

//--- verilog/adr_pkg.sv
/*
 * Shared constants and carriers for the accelerometer data and status register bank.
 * Assumes one system clock and a byte-wide register port driven by the serial front end.
 */
package adr_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADR_OFS_CHIP_IDENTITY = 8'h00;
    localparam logic [7:0] ADR_OFS_X_LOW = 8'h02;
    localparam logic [7:0] ADR_OFS_X_HIGH = 8'h03;
    localparam logic [7:0] ADR_OFS_Y_LOW = 8'h04;
    localparam logic [7:0] ADR_OFS_Y_HIGH = 8'h05;
    localparam logic [7:0] ADR_OFS_Z_LOW = 8'h06;
    localparam logic [7:0] ADR_OFS_Z_HIGH = 8'h07;
    localparam logic [7:0] ADR_OFS_MOTION_STATUS = 8'h09;
    localparam logic [7:0] ADR_OFS_DATA_FIFO_STATUS = 8'h0a;
    localparam logic [7:0] ADR_OFS_SLOPE_INFO = 8'h0b;
    localparam logic [7:0] ADR_OFS_FIFO_STATUS = 8'h0c;
    localparam logic [7:0] ADR_OFS_RANGE_SELECT = 8'h0f;
    localparam logic [7:0] ADR_OFS_POWER_MODE = 8'h11;
    localparam logic [7:0] ADR_OFS_FIFO_READ_PORT = 8'h3f;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ADR_BIT_SIG_MOTION = 0;
    localparam int ADR_BIT_SLOPE_MOTION = 2;
    localparam int ADR_BIT_FIFO_FULL = 5;
    localparam int ADR_BIT_FIFO_WM = 6;
    localparam int ADR_BIT_NEW_SAMPLE = 7;
    localparam int ADR_BIT_ORIGIN_LSB = 0;
    localparam int ADR_BIT_POLARITY_LSB = 4;
    localparam int ADR_BIT_OVERRUN = 7;
    localparam int ADR_BIT_SUSPEND = 7;

    // ****************************************************************
    // Reset values and range codes
    // ****************************************************************
    localparam logic [7:0] ADR_RST_BYTE = 8'h00;
    localparam logic [3:0] ADR_RANGE_2G = 4'h3;
    localparam logic [3:0] ADR_RANGE_4G = 4'h5;
    localparam logic [3:0] ADR_RANGE_8G = 4'h8;
    localparam logic [3:0] ADR_RST_RANGE = ADR_RANGE_2G;

    // Decoded full scale presented to the sensing chain.
    typedef enum logic [1:0] {
        ADR_SCALE_2G = 2'b00,
        ADR_SCALE_4G = 2'b01,
        ADR_SCALE_8G = 2'b10,
        ADR_SCALE_UNDEF = 2'b11
    } adr_scale_t;

    // Per-axis slope detector report.
    typedef struct packed {
        logic [2:0] origin;
        logic [2:0] polarity;
    } adr_slope_t;

    // Register port request from the serial front end.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adr_req_t;

endpackage

//--- verilog/adr_range_decode.sv
/*
 * Range code decoder: maps the four-bit range field to a full-scale selection.
 * Assumes a registered input from the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module adr_range_decode
    import adr_pkg::*;
(
    // Code in.
    input wire logic [3:0] code,
    // Scale out.
    output adr_scale_t scale
);

    // Only three codes have a defined full scale; the rest are flagged undefined.
    assign scale = (code == ADR_RANGE_2G) ? ADR_SCALE_2G :
                   (code == ADR_RANGE_4G) ? ADR_SCALE_4G :
                   (code == ADR_RANGE_8G) ? ADR_SCALE_8G :
                   ADR_SCALE_UNDEF;

endmodule

`default_nettype wire

//--- verilog/adr_regs.sv
/*
 * Data and status register bank of a three-axis accelerometer.
 * Assumes the serial front end issues one-cycle read and write strobes on this clock,
 * and the sensing core delivers samples and event pulses on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module adr_regs
    import adr_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a, // Arbitrary value.
    parameter int FILL_W = 7
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register port.
    input wire adr_req_t req,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    output logic fifo_pop_q,
    // Sensing core inputs.
    input wire logic sample_valid,
    input wire logic [11:0] x_accel_result,
    input wire logic [11:0] y_accel_result,
    input wire logic [11:0] z_accel_result,
    input wire logic significant_motion_flag,
    input wire logic slope_motion_flag,
    input wire adr_slope_t slope_report,
    input wire logic fifo_full_flag,
    input wire logic fifo_watermark_flag,
    input wire logic new_sample_flag,
    input wire logic overrun_event,
    input wire logic [FILL_W-1:0] fifo_fill_count,
    input wire logic [7:0] fifo_read_data,
    // Controls to the sensing core.
    output adr_scale_t scale_q,
    output logic suspend_q
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [11:0] x_q;
    logic [11:0] y_q;
    logic [11:0] z_q;
    logic [7:0] motion_q;
    logic [7:0] data_fifo_q;
    logic [7:0] slope_q;
    logic fifo_overrun_flag_q;
    logic [FILL_W-1:0] fill_q;
    logic [3:0] range_q;
    logic suspend_d;
    logic [3:0] range_d;
    logic overrun_d;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic wr_range = req.wr && (req.addr == ADR_OFS_RANGE_SELECT);
    wire logic wr_power = req.wr && (req.addr == ADR_OFS_POWER_MODE);
    wire logic rd_port = req.rd && (req.addr == ADR_OFS_FIFO_READ_PORT);
    wire adr_scale_t scale_w;

    // Status bytes from the core; reserved positions stay zero.
    wire logic [7:0] motion_w = (8'(significant_motion_flag) << ADR_BIT_SIG_MOTION)
                              | (8'(slope_motion_flag) << ADR_BIT_SLOPE_MOTION);
    wire logic [7:0] data_fifo_w = (8'(fifo_full_flag) << ADR_BIT_FIFO_FULL)
                                 | (8'(fifo_watermark_flag) << ADR_BIT_FIFO_WM)
                                 | (8'(new_sample_flag) << ADR_BIT_NEW_SAMPLE);
    wire logic [7:0] slope_w = (8'(slope_report.origin) << ADR_BIT_ORIGIN_LSB)
                             | (8'(slope_report.polarity) << ADR_BIT_POLARITY_LSB);

    // Set wins over the read clear so an overrun in the clearing cycle is kept.
    assign overrun_d = overrun_event ? 1'b1 : (rd_port ? 1'b0 : fifo_overrun_flag_q);
    // Only the low nibble is writable; upper bits are reserved.
    assign range_d = wr_range ? req.wdata[3:0] : range_q;
    assign suspend_d = wr_power ? req.wdata[ADR_BIT_SUSPEND] : suspend_q;

    // Low nibble of a result goes to the top half of the low byte.
    function automatic logic [7:0] low_byte(input logic [11:0] v);
        low_byte = {v[3:0], 4'h0};
    endfunction

    // Read multiplexer; unmapped offsets read zero.
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        read_mux = ADR_RST_BYTE;
        unique case (a)
            ADR_OFS_CHIP_IDENTITY: read_mux = IDENTITY_VALUE;
            ADR_OFS_X_LOW: read_mux = low_byte(x_q);
            ADR_OFS_X_HIGH: read_mux = x_q[11:4];
            ADR_OFS_Y_LOW: read_mux = low_byte(y_q);
            ADR_OFS_Y_HIGH: read_mux = y_q[11:4];
            ADR_OFS_Z_LOW: read_mux = low_byte(z_q);
            ADR_OFS_Z_HIGH: read_mux = z_q[11:4];
            ADR_OFS_MOTION_STATUS: read_mux = motion_q;
            ADR_OFS_DATA_FIFO_STATUS: read_mux = data_fifo_q;
            ADR_OFS_SLOPE_INFO: read_mux = slope_q;
            ADR_OFS_FIFO_STATUS: read_mux = {fifo_overrun_flag_q, 7'(fill_q)};
            ADR_OFS_RANGE_SELECT: read_mux = {4'h0, range_q};
            ADR_OFS_POWER_MODE: read_mux = {suspend_q, 7'h00};
            ADR_OFS_FIFO_READ_PORT: read_mux = fifo_read_data;
            default: read_mux = ADR_RST_BYTE;
        endcase
    endfunction

    adr_range_decode u_range_decode (
        .code(range_q),
        .scale(scale_w)
    );

    // ****************************************************************
    // Sample capture
    // ****************************************************************
    // Results update only with a fresh sample; suspend freezes them so a range change
    // made while suspended never shows a half-scaled sample.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x_q <= 12'h000;
            y_q <= 12'h000;
            z_q <= 12'h000;
        end
        else if (sample_valid && !suspend_q)
        begin
            x_q <= x_accel_result;
            y_q <= y_accel_result;
            z_q <= z_accel_result;
        end
    end

    // ****************************************************************
    // Status and control
    // ****************************************************************
    // Status mirrors the core level each cycle, except the overrun flag, held until a FIFO port read; no host write can reach it.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            motion_q <= ADR_RST_BYTE;
            data_fifo_q <= ADR_RST_BYTE;
            slope_q <= ADR_RST_BYTE;
            fill_q <= '0;
            fifo_overrun_flag_q <= 1'b0;
            range_q <= ADR_RST_RANGE;
            suspend_q <= 1'b0;
            scale_q <= ADR_SCALE_2G;
        end
        else
        begin
            motion_q <= motion_w;
            data_fifo_q <= data_fifo_w;
            slope_q <= slope_w;
            fill_q <= fifo_fill_count;
            fifo_overrun_flag_q <= overrun_d;
            range_q <= range_d;
            suspend_q <= suspend_d;
            scale_q <= scale_w;
        end
    end

    // ****************************************************************
    // Read answer
    // ****************************************************************
    // Data is returned one cycle after the read strobe.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= ADR_RST_BYTE;
            rvalid_q <= 1'b0;
            fifo_pop_q <= 1'b0;
        end
        else
        begin
            rdata_q <= req.rd ? read_mux(req.addr) : rdata_q;
            rvalid_q <= req.rd;
            fifo_pop_q <= rd_port;
        end
    end

endmodule

`default_nettype wire
